// ### rtl/fos_pkg.sv
// package: forced output stop control constants and register layout
package fos_pkg;

	localparam int          FOS_NUM_INST  = 2;
	localparam int          FOS_ADDR_W    = 20;
	localparam int          FOS_DATA_W    = 16;
	localparam int          FOS_NUM_CMP   = 3;

	localparam logic [19:0] FOS_ADDR_CTL0 = 20'hF0630;
	localparam logic [19:0] FOS_ADDR_CTL1 = 20'hF0632;
	localparam logic [19:0] FOS_ADDR_REL  = 20'hF0634;
	localparam logic [19:0] FOS_ADDR_STAT = 20'hF0636;

	localparam logic [15:0] FOS_CTL_RESET = 16'h0000;
	localparam logic [15:0] FOS_CTL_MASK  = 16'hF17F;
	localparam logic [15:0] FOS_RD_ZERO   = 16'h0000;

	localparam logic [1:0]  FOS_CC_NOW     = 2'h0;
	localparam logic [1:0]  FOS_CC_NOW_INA = 2'h1;
	localparam logic [1:0]  FOS_CC_PER     = 2'h2;
	localparam logic [1:0]  FOS_CC_PER_INA = 2'h3;

	// control register image, bit 15 first
	typedef struct packed {
		logic       f2_pin_trigger_enable;
		logic [2:0] f2_comparator_enable;
		logic [2:0] rsvd_hi;
		logic       f2_release_mode;
		logic       rsvd_lo;
		logic [2:0] f1_comparator_enable;
		logic       f1_clear_cond_hi;
		logic       f1_clear_cond_lo;
		logic       output_state_sel_hi;
		logic       output_state_sel_lo;
	} fos_ctl_s;

	// forced pin state of one timer instance
	typedef struct packed {
		logic hiz;
		logic drive;
		logic level;
	} fos_out_s;

endpackage

// ### rtl/fos_sync.sv
// two-flop synchroniser plus one history flop for edge detection
`timescale 1ns/100ps
`default_nettype none
module fos_sync #(
	parameter int WIDTH = 4
) (
	// clock and reset
	input  wire logic             clock,
	input  wire logic             rst_b,
	// asynchronous levels in
	input  wire logic [WIDTH-1:0] async_in,
	// synchronised level and its previous value
	output logic      [WIDTH-1:0] sync_out,
	output logic      [WIDTH-1:0] sync_prev
);

	logic [WIDTH-1:0] meta_r;

	// first flop feeds only the second one
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			meta_r   <= '0;
			sync_out <= '0;
		end else begin
			meta_r   <= async_in;
			sync_out <= meta_r;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			sync_prev <= '0;
		end else begin
			sync_prev <= sync_out;
		end
	end

endmodule
`default_nettype wire

// ### rtl/fos_top.sv
// forced output stop control: registers, two stop instances, forced pin states
`timescale 1ns/100ps
`default_nettype none
module fos_top
	import fos_pkg::*;
(
	// clock and reset
	input  wire logic                    clock,
	input  wire logic                    rst_b,
	// register port
	input  wire logic [FOS_ADDR_W-1:0]   reg_addr,
	input  wire logic [FOS_DATA_W-1:0]   reg_wdata,
	input  wire logic                    reg_wr,
	input  wire logic                    reg_rd,
	output logic      [FOS_DATA_W-1:0]   reg_rdata_r,
	// trigger sources, asynchronous
	input  wire logic                    comparator_zero,
	input  wire logic                    comparator_one,
	input  wire logic                    comparator_two,
	input  wire logic                    external_irq_pin,
	// timer status, same clock
	input  wire logic [FOS_NUM_INST-1:0] timer_run_enable,
	input  wire logic [FOS_NUM_INST-1:0] period_start,
	// stop state and forced outputs
	output logic      [FOS_NUM_INST-1:0] f1_active_r,
	output logic      [FOS_NUM_INST-1:0] f2_active_r,
	output logic      [FOS_NUM_INST-1:0] stop_hiz_r,
	output logic      [FOS_NUM_INST-1:0] stop_drive_r,
	output logic      [FOS_NUM_INST-1:0] stop_level_r
);

	fos_ctl_s                  ctl_r     [FOS_NUM_INST];
	logic [FOS_NUM_INST-1:0]   f1_act_r;
	logic [FOS_NUM_INST-1:0]   f1_pend_r;
	logic [FOS_NUM_INST-1:0]   f2_act_r;
	logic [FOS_NUM_INST-1:0]   f2_rev_r;
	logic [FOS_NUM_INST-1:0]   run_q_r;
	logic [FOS_NUM_INST-1:0]   trig1_q_r;
	logic [FOS_NUM_INST-1:0]   trig2_q_r;
	logic [FOS_NUM_INST-1:0]   f1_act_nxt;
	logic [FOS_NUM_INST-1:0]   f1_pend_nxt;
	logic [FOS_NUM_INST-1:0]   f2_act_nxt;
	logic [FOS_NUM_INST-1:0]   f2_rev_nxt;
	logic [FOS_NUM_INST-1:0]   trig1;
	logic [FOS_NUM_INST-1:0]   trig2;
	logic [FOS_NUM_INST-1:0]   f1_rise;
	logic [FOS_NUM_INST-1:0]   f2_rise;
	logic [FOS_NUM_INST-1:0]   f2_fall;
	logic [FOS_NUM_INST-1:0]   period_evt;
	logic [FOS_NUM_INST-1:0]   rel_wr;
	fos_out_s                  out_nxt   [FOS_NUM_INST];
	logic [FOS_NUM_CMP-1:0]    cmp_s;
	logic [FOS_NUM_CMP:0]      src_s;
	logic                      pin_s;
	logic                      wr_ctl0;
	logic                      wr_ctl1;
	logic                      wr_rel;
	logic [FOS_DATA_W-1:0]     rdata_nxt;

	// pins come from other clock domains
	fos_sync #(
		.WIDTH (FOS_NUM_CMP + 1)
	) u_sync (
		.clock     (clock),
		.rst_b     (rst_b),
		.async_in  ({external_irq_pin, comparator_two, comparator_one, comparator_zero}),
		.sync_out  (src_s),
		// history left open: edges are taken after source selection, per instance
		.sync_prev ()
	);

	assign cmp_s   = src_s[FOS_NUM_CMP-1:0];
	assign pin_s   = src_s[FOS_NUM_CMP];
	assign wr_ctl0 = reg_wr && (reg_addr == FOS_ADDR_CTL0);
	assign wr_ctl1 = reg_wr && (reg_addr == FOS_ADDR_CTL1);
	assign wr_rel  = reg_wr && (reg_addr == FOS_ADDR_REL);

	// next state of function 1: {active, release pending}
	function automatic logic [1:0] f1_step(
		input logic       act,
		input logic       pend,
		input logic [1:0] cc,
		input logic       rel,
		input logic       trig,
		input logic       rise,
		input logic       per
	);
		logic a;
		logic p;
		a = act;
		p = pend;
		if (act) begin
			case (cc)
				FOS_CC_NOW: begin
					if (rel) a = 1'b0;
				end
				FOS_CC_NOW_INA: begin
					if (rel && !trig) a = 1'b0;
				end
				FOS_CC_PER: begin
					if (rel) p = 1'b1;
				end
				FOS_CC_PER_INA: begin
					if (rel && !trig) p = 1'b1;
				end
				default: begin
					a = act;
				end
			endcase
			// period events only while the timer runs
			if (pend && per) begin
				a = 1'b0;
			end
		end
		if (!a) begin
			p = 1'b0;
		end
		// engage beats any release in the same cycle
		if (rise) begin
			a = 1'b1;
			p = 1'b0;
		end
		return {a, p};
	endfunction

	// next state of function 2: {active, reverse edge seen}
	function automatic logic [1:0] f2_step(
		input logic act,
		input logic rev,
		input logic mode,
		input logic fall,
		input logic rise,
		input logic per
	);
		logic a;
		logic r;
		a = act;
		r = rev;
		if (act) begin
			if (!mode) begin
				if (per) a = 1'b0;
			end else begin
				if (rev && per) a = 1'b0;
				if (fall) r = 1'b1;
			end
		end
		if (!a) begin
			r = 1'b0;
		end
		if (rise) begin
			a = 1'b1;
			r = 1'b0;
		end
		return {a, r};
	endfunction

	// control registers, reserved bits never stored
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			ctl_r[0] <= fos_ctl_s'(FOS_CTL_RESET);
			ctl_r[1] <= fos_ctl_s'(FOS_CTL_RESET);
		end else begin
			if (wr_ctl0) ctl_r[0] <= fos_ctl_s'(reg_wdata & FOS_CTL_MASK);
			if (wr_ctl1) ctl_r[1] <= fos_ctl_s'(reg_wdata & FOS_CTL_MASK);
		end
	end

	// read data stand for exactly one cycle after the strobe
	always_comb begin
		rdata_nxt = FOS_RD_ZERO;
		if (reg_rd) begin
			case (reg_addr)
				FOS_ADDR_CTL0: rdata_nxt = ctl_r[0];
				FOS_ADDR_CTL1: rdata_nxt = ctl_r[1];
				FOS_ADDR_STAT: rdata_nxt = {12'h000, f2_act_r, f1_act_r};
				default:       rdata_nxt = FOS_RD_ZERO;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata_r <= FOS_RD_ZERO;
		end else begin
			reg_rdata_r <= rdata_nxt;
		end
	end

	for (genvar i = 0; i < FOS_NUM_INST; i++) begin : g_inst
		// any enabled source engages the function
		assign trig1[i] = |(ctl_r[i].f1_comparator_enable & cmp_s);
		// pin and comparators for function 2
		assign trig2[i] = (|(ctl_r[i].f2_comparator_enable & cmp_s))
			|| (ctl_r[i].f2_pin_trigger_enable && pin_s);
		assign f1_rise[i] = trig1[i] && !trig1_q_r[i];
		assign f2_rise[i] = trig2[i] && !trig2_q_r[i];
		assign f2_fall[i] = !trig2[i] && trig2_q_r[i];
		// a restart stands in for the missed period
		assign period_evt[i] = timer_run_enable[i]
			&& (period_start[i] || !run_q_r[i]);
		assign rel_wr[i] = wr_rel && reg_wdata[i];
		assign {f1_act_nxt[i], f1_pend_nxt[i]} = f1_step(f1_act_r[i], f1_pend_r[i],
			{ctl_r[i].f1_clear_cond_hi, ctl_r[i].f1_clear_cond_lo},
			rel_wr[i], trig1[i], f1_rise[i], period_evt[i]);
		assign {f2_act_nxt[i], f2_rev_nxt[i]} = f2_step(f2_act_r[i], f2_rev_r[i],
			ctl_r[i].f2_release_mode, f2_fall[i], f2_rise[i], period_evt[i]);
		// function 1 wins; its hi-z only for codes 0x
		assign out_nxt[i].hiz   = f1_act_nxt[i] && !ctl_r[i].output_state_sel_hi;
		assign out_nxt[i].drive = (f1_act_nxt[i] && ctl_r[i].output_state_sel_hi)
			|| (f2_act_nxt[i] && !f1_act_nxt[i]);
		assign out_nxt[i].level = ctl_r[i].output_state_sel_lo;
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			f1_act_r  <= '0;
			f1_pend_r <= '0;
			f2_act_r  <= '0;
			f2_rev_r  <= '0;
		end else begin
			f1_act_r  <= f1_act_nxt;
			f1_pend_r <= f1_pend_nxt;
			f2_act_r  <= f2_act_nxt;
			f2_rev_r  <= f2_rev_nxt;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			run_q_r   <= '0;
			trig1_q_r <= '0;
			trig2_q_r <= '0;
		end else begin
			run_q_r   <= timer_run_enable;
			trig1_q_r <= trig1;
			trig2_q_r <= trig2;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			f1_active_r  <= '0;
			f2_active_r  <= '0;
			stop_hiz_r   <= '0;
			stop_drive_r <= '0;
			stop_level_r <= '0;
		end else begin
			f1_active_r <= f1_act_nxt;
			f2_active_r <= f2_act_nxt;
			for (int k = 0; k < FOS_NUM_INST; k++) begin
				stop_hiz_r[k]   <= out_nxt[k].hiz;
				stop_drive_r[k] <= out_nxt[k].drive;
				stop_level_r[k] <= out_nxt[k].level;
			end
		end
	end

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_b);

	AST_CTL0_READ: assert property (
		reg_rd && reg_addr == FOS_ADDR_CTL0 && !wr_ctl0
		|=> reg_rdata_r == $past(ctl_r[0]))
		else $error("control 0 read mismatch");

	AST_RESERVED_ZERO: assert property (
		reg_rd ##1 1'b1 |-> (reg_rdata_r & ~FOS_CTL_MASK) == FOS_RD_ZERO
			|| $past(reg_addr) == FOS_ADDR_STAT)
		else $error("reserved control bits read nonzero");

	for (genvar j = 0; j < FOS_NUM_INST; j++) begin : g_chk
		AST_F2_SOURCE: assert property (
			!f2_act_r[j] && !ctl_r[j].f2_pin_trigger_enable
			&& ctl_r[j].f2_comparator_enable == 3'h0 |=> !f2_act_r[j])
			else $error("function 2 engaged without enabled source");

		AST_F2_ENGAGE: assert property (
			$rose(trig2[j]) |=> f2_act_r[j] ##0 f2_active_r[j])
			else $error("function 2 did not engage");

		AST_F2_MODE0: assert property (
			f2_act_r[j] && !ctl_r[j].f2_release_mode && period_evt[j]
			&& !f2_rise[j] |=> !f2_act_r[j])
			else $error("function 2 mode 0 not released at period");

		AST_F2_MODE1: assert property (
			f2_act_r[j] && ctl_r[j].f2_release_mode && !f2_rev_r[j]
			&& !f2_rise[j] |=> f2_act_r[j])
			else $error("function 2 released before reverse edge");

		AST_F1_SOURCE: assert property (
			!f1_act_r[j] ##1 f1_act_r[j] |-> $past(trig1[j]))
			else $error("function 1 engaged without enabled source");

		AST_F1_NOW: assert property (
			f1_act_r[j] && ctl_r[j].f1_clear_cond_hi == 1'b0
			&& ctl_r[j].f1_clear_cond_lo == 1'b0 && rel_wr[j]
			&& !f1_rise[j] |=> !f1_act_r[j] [*2])
			else $error("function 1 not released by write");

		AST_F1_ACTIVE_IGN: assert property (
			f1_act_r[j] && !f1_pend_r[j] && ctl_r[j].f1_clear_cond_hi == 1'b0
			&& ctl_r[j].f1_clear_cond_lo && rel_wr[j] && trig1[j]
			|=> f1_act_r[j])
			else $error("release honoured while trigger active");

		AST_F1_PERIOD: assert property (
			f1_act_r[j] && ctl_r[j].f1_clear_cond_hi && !ctl_r[j].f1_clear_cond_lo
			&& rel_wr[j] && !f1_rise[j] && !f1_pend_r[j]
			|=> f1_act_r[j] && f1_pend_r[j])
			else $error("deferred release not held pending");

		AST_F1_PERIOD_INA: assert property (
			f1_act_r[j] && ctl_r[j].f1_clear_cond_hi && ctl_r[j].f1_clear_cond_lo
			&& rel_wr[j] && trig1[j] && !f1_pend_r[j] |=> !f1_pend_r[j])
			else $error("active-trigger release armed");

		AST_OUT_STATE: assert property (
			f1_act_r[j] && $stable(ctl_r[j]) |-> stop_hiz_r[j]
			== !ctl_r[j].output_state_sel_hi && stop_level_r[j]
			== ctl_r[j].output_state_sel_lo)
			else $error("forced output state mismatch");

		AST_RUN_HOLD: assert property (
			f2_act_r[j] && !timer_run_enable[j] && !run_q_r[j]
			|=> f2_act_r[j] && f2_active_r[j])
			else $error("stop released while timer halted");

		COV_F1_CYCLE: cover property (
			f1_rise[j] ##[1:50] !f1_act_r[j]);
		COV_F2_REVERSE: cover property (
			ctl_r[j].f2_release_mode && f2_fall[j] && f2_act_r[j]
			##[1:50] !f2_act_r[j]);
		COV_RESTART: cover property (
			f2_act_r[j] && !timer_run_enable[j] ##1 timer_run_enable[j]);
	end

	COV_PIN_TRIGGER: cover property (
		ctl_r[0].f2_pin_trigger_enable && $rose(pin_s) ##1 f2_act_r[0]);

endmodule
`default_nettype wire

// ### sim/fos_trig_model.sv
// trigger source model: comparator outputs and external pin levels
`timescale 1ns/100ps
`default_nettype none
module fos_trig_model (
	// clock
	input  wire logic       clock,
	// commanded levels {pin, comparator_two, comparator_one, comparator_zero} and slow mode
	input  wire logic [3:0] level_cmd,
	input  wire logic       lag,
	// source levels towards the block
	output logic            comparator_zero,
	output logic            comparator_one,
	output logic            comparator_two,
	output logic            external_irq_pin
);
	logic [3:0] hold_r;

	always_ff @(posedge clock) begin
		hold_r <= level_cmd;
	end

	// slow mode trails the command by one cycle, as a sluggish comparator would
	assign {external_irq_pin, comparator_two, comparator_one, comparator_zero} =
		lag ? hold_r : level_cmd;
endmodule
`default_nettype wire

// ### sim/fos_top_tb.sv
// self-checking bench for the forced output stop control
`timescale 1ns/100ps
`default_nettype none
module fos_top_tb;
	import fos_pkg::*;
	logic        clock;
	logic        rst_b;
	logic        reg_wr;
	logic        reg_rd;
	logic        lag;
	logic [19:0] reg_addr;
	logic [15:0] reg_wdata;
	logic [15:0] reg_rdata_r;
	logic [15:0] v;
	logic [15:0] rd_v;
	logic [3:0]  src;
	logic [1:0]  run;
	logic [1:0]  per;
	logic [1:0]  f1;
	logic [1:0]  f2;
	logic [1:0]  hiz;
	logic [1:0]  drv;
	logic [1:0]  lvl;
	wire         c0;
	wire         c1;
	wire         c2;
	wire         pin;
	int          error_cnt;
	int          cmp_count;
	int          cyc;
	int          seed;
	int          i;
	int          k;

	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	fos_top fos_top_i (
		.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
		.comparator_zero(c0), .comparator_one(c1), .comparator_two(c2),
		.external_irq_pin(pin), .timer_run_enable(run), .period_start(per),
		.f1_active_r(f1), .f2_active_r(f2), .stop_hiz_r(hiz),
		.stop_drive_r(drv), .stop_level_r(lvl)
	);

	fos_trig_model fos_trig_model_i (
		.clock(clock), .level_cmd(src), .lag(lag), .comparator_zero(c0),
		.comparator_one(c1), .comparator_two(c2), .external_irq_pin(pin)
	);

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [19:0] a, input logic [15:0] d);
		@(posedge clock);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [19:0] a, output logic [15:0] d);
		@(posedge clock);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		@(negedge clock);
		d = reg_rdata_r;
	endtask

	// settings change only while the timer is stopped
	task automatic cfg(input int n, input logic [15:0] d);
		@(posedge clock);
		run[n] <= 1'b0;
		wr(FOS_ADDR_CTL0 + 20'(2 * n), d);
		run[n] <= 1'b1;
	endtask

	task automatic wt(input int n);
		repeat (n) @(negedge clock);
	endtask

	task automatic sv(input logic [3:0] s);
		@(posedge clock);
		src <= s;
	endtask

	task automatic prd(input int n);
		@(posedge clock);
		per[n] <= 1'b1;
		@(posedge clock);
		per <= 2'b00;
	endtask

	task automatic print_verdict;
		$display("counts: %0d compares, %0d mismatches", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// the whole run needs well under 2000 cycles
	always @(posedge clock) begin
		cyc++;
		if (cyc == 5000) begin
			error_cnt++;
			print_verdict;
		end
	end

	initial begin
		seed      = 32'h8bc4f5f6;
		rst_b     = 1'b0;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
		lag       = 1'b0;
		reg_addr  = 20'h00000;
		reg_wdata = 16'h0000;
		src       = 4'h0;
		run       = 2'b11;
		per       = 2'b00;
		error_cnt = 0;
		cmp_count = 0;
		cyc       = 0;
		repeat (4) @(posedge clock);
		rst_b <= 1'b1;
		for (i = 0; i < 2; i++) begin
			rd(FOS_ADDR_CTL0 + 20'(2 * i), v);
			chk(v, FOS_CTL_RESET);
			v = 16'($random(seed)) & FOS_CTL_MASK;
			cfg(i, v);
			rd(FOS_ADDR_CTL0 + 20'(2 * i), rd_v);
			chk(rd_v, v & FOS_CTL_MASK);
		end
		rd(20'hF0640, v);
		chk(v, 16'h0000);
		$display("test registers done");
		// instance 1 must stay quiet while instance 0 sources are swept
		cfg(1, 16'h0000);
		for (k = 0; k < 4; k++) begin
			v = 16'h1000 << k;
			if (k < 3)
				v = v | (16'h0010 << k);
			cfg(0, v);
			lag <= 1'($random(seed));
			sv(4'h1 << k);
			wt(7);
			chk({12'h000, f2, f1}, {12'h000, 3'b010, 1'(k < 3)});
			wr(FOS_ADDR_REL, 16'h0001);
			prd(0);
			wt(2);
			chk({12'h000, f2, f1}, 16'h0000);
			// sources left disabled must not engage anything
			sv(~(4'h1 << k));
			wt(7);
			chk({12'h000, f2, f1}, 16'h0000);
			sv(4'h0);
			wt(5);
		end
		$display("test sources done");
		for (i = 0; i < 2; i++)
			for (k = 0; k < 4; k++) begin
				cfg(i, 16'h0010 | 16'(k << 2) | 16'(k));
				sv(4'h1);
				wt(7);
				chk({13'h0, hiz[i], drv[i], lvl[i]}, {13'h0, ~k[1], k[1], k[0]});
				wr(FOS_ADDR_REL, 16'(1 << i));
				wt(2);
				chk(16'(f1[i]), 16'(k != 0));
				if (k[0]) begin
					sv(4'h0);
					wt(5);
					wr(FOS_ADDR_REL, 16'(1 << i));
					wt(2);
					chk(16'(f1[i]), 16'(k == 3));
				end
				if (k[1]) begin
					prd(i);
					wt(2);
					chk(16'(f1[i]), 16'h0000);
				end
				sv(4'h0);
				wt(5);
			end
		$display("test release codes done");
		v = 16'h1000 | 16'($random(seed) & 1);
		cfg(1, v);
		sv(4'h1);
		wt(7);
		chk({13'h0, hiz[1], drv[1], lvl[1]}, {13'h0, 2'b01, v[0]});
		// status: f2 of instance 1 and f1 of instance 0 (code 11, re-engaged in the instance 1 sweep and not released since)
		rd(FOS_ADDR_STAT, rd_v);
		chk(rd_v, 16'h0009);
		@(posedge clock);
		run <= 2'b01;
		prd(1);
		wt(3);
		chk(16'(f2[1]), 16'h0001);
		@(posedge clock);
		run <= 2'b11;
		wt(2);
		chk(16'(f2[1]), 16'h0000);
		sv(4'h0);
		wt(5);
		$display("test timer stop done");
		cfg(0, 16'h1100);
		sv(4'h1);
		wt(7);
		prd(0);
		wt(2);
		chk(16'(f2[0]), 16'h0001);
		sv(4'h0);
		wt(5);
		chk(16'(f2[0]), 16'h0001);
		prd(0);
		wt(2);
		chk(16'(f2[0]), 16'h0000);
		$display("test reverse edge done");
		print_verdict;
	end
endmodule
`default_nettype wire
